/* pkg/rmfc_cfg.svh */
/*
 * Constants of the regulator monitor and fault control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef RMFC_CFG_SVH
`define RMFC_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RMFC_A_CTRL 8'h00
`define RMFC_A_INJECT 8'h04
`define RMFC_A_LATSEL 8'h08
`define RMFC_A_OTLIM 8'h0C
`define RMFC_A_STATUS 8'h10
`define RMFC_A_VOUT 8'h14
`define RMFC_A_IOUT 8'h18
`define RMFC_A_TEMP 8'h1C
`define RMFC_A_DUTY 8'h20
`define RMFC_A_ISTAT 8'h24
`define RMFC_A_IMASK 8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RMFC_CTRL_ON 0
`define RMFC_ST_STATE 0
`define RMFC_ST_FAULT 8
`define RMFC_ST_GRPDN 12
`define RMFC_ST_TRIM 13
`define RMFC_EV_FAULT 0
`define RMFC_EV_RESTART 1
`define RMFC_EV_CLEAR 2
`define RMFC_EV_MEAS 3

// ----------------------------------------------------------------------
// reset values and analog scaling
// ----------------------------------------------------------------------
`define RMFC_OTLIM_RST 8'h7D
`define RMFC_TREF 8'h19
`define RMFC_TC_SHIFT 8
`define RMFC_SHARE_MARGIN 8'h02

// ----------------------------------------------------------------------
// timing: hiccup counted in switching-clock edges, rounded up
// ----------------------------------------------------------------------
`define RMFC_SW_NS 2000
`define RMFC_HICCUP_MS 130
`define RMFC_HIC_EDGES \
    ((`RMFC_HICCUP_MS * 1000000 + `RMFC_SW_NS - 1) / `RMFC_SW_NS)

`endif

/* pkg/rmfc_pkg.sv */
/*
 * Types of the regulator monitor and fault control block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package rmfc_pkg;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_RUN = 5'h02,
        ST_FLT = 5'h04,
        ST_HIC = 5'h08,
        ST_LAT = 5'h10
    } rmfc_state_t;

    typedef enum logic [1:0] {
        CH_VOUT = 2'h0,
        CH_IOUT = 2'h1,
        CH_TEMP = 2'h2
    } rmfc_chan_t;

endpackage : rmfc_pkg
`default_nettype wire

/* pkg/rmfc_meas_if.sv */
/*
 * Readings and load-share results passed between the monitor, the
 * share-line engine and the top of the block.
 * Assumes all users run on ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface rmfc_meas_if;
    logic [11:0] vout_q;
    logic [7:0] iout_q;
    logic [7:0] temp_q;
    logic upd_q;
    logic [7:0] duty_q;
    logic trim_q;

    modport mon (output vout_q, iout_q, temp_q, upd_q);
    modport shr (input iout_q, output duty_q, trim_q);
    modport top (input vout_q, iout_q, temp_q, upd_q, duty_q, trim_q);
endinterface : rmfc_meas_if
`default_nettype wire

/* verilog/rmfc_monitor.sv */
/*
 * Converter sequencer: walks voltage, current and temperature without
 * pause and temperature-corrects the current reading.
 * Assumes a converter on ref_clk answering each start with adc_done.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rmfc_cfg.svh"
module rmfc_monitor
    import rmfc_pkg::*;
#(
    parameter int TC_SHIFT = `RMFC_TC_SHIFT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // converter handshake
    input wire logic adc_done,
    input wire logic [11:0] adc_data,
    output logic adc_start_q,
    output var rmfc_chan_t adc_chan_q,
    // readings
    rmfc_meas_if.mon meas
);
    logic busy_q;
    logic [7:0] iraw;
    logic signed [8:0] dt;
    logic signed [17:0] prod;
    logic signed [17:0] adj;
    logic signed [10:0] corr;
    logic [7:0] icorr;

    // copper resistance rises about 1/256 per degree: scale the reading
    assign iraw = adc_data[11:4];
    assign dt = $signed({1'b0, meas.temp_q}) - $signed({1'b0, `RMFC_TREF});
    assign prod = $signed({1'b0, iraw}) * dt;
    assign adj = prod >>> TC_SHIFT;
    assign corr = $signed({3'b000, iraw}) - $signed(adj[10:0]);
    assign icorr = corr[10] ? 8'h00 : ((|corr[9:8]) ? 8'hFF : corr[7:0]);

    // never idles, so readings stay fresh with or without polling
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            adc_start_q <= 1'b0;
            adc_chan_q <= CH_VOUT;
        end else begin
            adc_start_q <= !busy_q;
            if (!busy_q) begin
                busy_q <= 1'b1;
            end else if (adc_done) begin
                busy_q <= 1'b0;
                case (adc_chan_q)
                    CH_VOUT: adc_chan_q <= CH_IOUT;
                    CH_IOUT: adc_chan_q <= CH_TEMP;
                    default: adc_chan_q <= CH_VOUT;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meas.vout_q <= 12'h000;
            meas.iout_q <= 8'h00;
            meas.temp_q <= 8'h00;
            meas.upd_q <= 1'b0;
        end else begin
            meas.upd_q <= busy_q && adc_done && adc_chan_q == CH_TEMP;
            if (busy_q && adc_done) begin
                case (adc_chan_q)
                    CH_VOUT: meas.vout_q <= adc_data;
                    CH_IOUT: meas.iout_q <= icorr;
                    default: meas.temp_q <= iraw;
                endcase
            end
        end
    end

    a_mon_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        busy_q && adc_done |-> ##2 adc_start_q)
        else $error("converter sequence stalled");
    a_vout_full: assert property (@(posedge ref_clk) disable iff (rst)
        busy_q && adc_done && adc_chan_q == CH_VOUT
        |=> meas.vout_q == $past(adc_data))
        else $error("voltage reading lost bits");
    a_iout_tref: assert property (@(posedge ref_clk) disable iff (rst)
        busy_q && adc_done && adc_chan_q == CH_IOUT
        && meas.temp_q == `RMFC_TREF
        |=> meas.iout_q == $past(iraw))
        else $error("current corrected at reference temperature");
endmodule : rmfc_monitor
`default_nettype wire

/* verilog/rmfc_share.sv */
/*
 * Shared load line engine: drives a low time proportional to own load
 * current and compares the wired-AND line against it.
 * Assumes an open-drain line shared with the paralleled regulators.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rmfc_cfg.svh"
module rmfc_share
    import rmfc_pkg::*;
#(
    parameter logic [7:0] MARGIN = `RMFC_SHARE_MARGIN
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic drive_en,
    // pin
    input wire logic share_in,
    output logic share_oe_q,
    // results
    rmfc_meas_if.shr meas
);
    logic [1:0] sync_q;
    logic [7:0] cnt_q;
    logic [7:0] own_q;
    logic [7:0] low_q;
    logic frame_end;

    assign frame_end = cnt_q == 8'hFF;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_q <= 2'b11;
        end else begin
            sync_q <= {sync_q[0], share_in};
        end
    end

    // own request is frozen per frame so the low time is one clean pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            own_q <= 8'h00;
            share_oe_q <= 1'b0;
        end else begin
            cnt_q <= 8'(cnt_q + 8'h01);
            if (frame_end) begin
                own_q <= meas.iout_q;
            end
            share_oe_q <= drive_en && cnt_q < own_q;
        end
    end

    // the line is wired-AND, so its low time is the widest request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_q <= 8'h00;
            meas.duty_q <= 8'h00;
            meas.trim_q <= 1'b0;
        end else if (frame_end) begin
            low_q <= 8'h00;
            meas.duty_q <= low_q;
            meas.trim_q <= drive_en &&
                {1'b0, low_q} > {1'b0, own_q} + {1'b0, MARGIN};
        end else begin
            low_q <= 8'(low_q + {7'h00, !sync_q[1]});
        end
    end

    a_share_low: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(share_oe_q) && $past(drive_en)
        |-> $past(cnt_q) == $past(own_q))
        else $error("share low time differs from load");
    a_trim_up: assert property (@(posedge ref_clk) disable iff (rst)
        frame_end && drive_en
        && {1'b0, low_q} > {1'b0, own_q} + {1'b0, MARGIN}
        |=> meas.trim_q [*2])
        else $error("trim not raised for wider line duty");
endmodule : rmfc_share
`default_nettype wire

/* verilog/rmfc_top.sv */
/*
 * Supervisory logic of a point-of-load regulator: readings, fault
 * injection, hiccup and latched recovery, group health and load share.
 * Assumes a register port on ref_clk and pins from outside its domain.
 */
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rmfc_cfg.svh"
module rmfc_top
    import rmfc_pkg::*;
#(
    parameter int HIC_EDGES = `RMFC_HIC_EDGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // single-wire link, also the switching clock
    input wire logic sync_data_line,
    // group health line, open drain
    input wire logic health_in,
    output logic health_oe_q,
    // shared load line, open drain
    input wire logic share_in,
    output logic share_oe,
    output logic trim_up,
    // converter
    input wire logic adc_done,
    input wire logic [11:0] adc_data,
    output logic adc_start,
    output var rmfc_chan_t adc_chan,
    // protection and power stage
    input wire logic [2:0] fault_pin,
    input wire logic en_pin,
    output logic pwr_en_q,
    output logic irq_q
);
    localparam int HW = $clog2(HIC_EDGES + 1);

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    rmfc_meas_if meas ();
    rmfc_state_t state_q;
    rmfc_state_t state_d;
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic sd_d3_q;
    logic [1:0] oe_hist_q;
    logic sd_fall;
    logic en_s;
    logic health_s;
    logic [2:0] fault_s;
    logic ctrl_on_q;
    logic [3:0] inject_q;
    logic [3:0] latsel_q;
    logic [7:0] otlim_q;
    logic [3:0] istat_q;
    logic [3:0] istat_d;
    logic [3:0] imask_q;
    logic [3:0] imask_d;
    logic [3:0] ev;
    logic [3:0] fault_src;
    logic group_down;
    logic fault_now;
    logic latching;
    logic enable;
    logic [HW-1:0] hic_cnt_q;
    logic hic_done;
    logic [31:0] status_w;
    logic [31:0] rd_val;

    // ------------------------------------------------------------------
    // pin synchronisers; first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 6'h28;
            sync2_q <= 6'h28;
            sd_d3_q <= 1'b1;
            oe_hist_q <= 2'h0;
        end else begin
            sync1_q <= {sync_data_line, en_pin, health_in, fault_pin};
            sync2_q <= sync1_q;
            sd_d3_q <= sync2_q[5];
            oe_hist_q <= {oe_hist_q[0], health_oe_q};
        end
    end

    assign sd_fall = sd_d3_q && !sync2_q[5];
    assign en_s = sync2_q[4];
    assign health_s = sync2_q[3];
    assign fault_s = sync2_q[2:0];

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    rmfc_monitor u_mon (
        .ref_clk(ref_clk),
        .rst(rst),
        .adc_done(adc_done),
        .adc_data(adc_data),
        .adc_start_q(adc_start),
        .adc_chan_q(adc_chan),
        .meas(meas.mon)
    );

    rmfc_share u_share (
        .ref_clk(ref_clk),
        .rst(rst),
        .drive_en(pwr_en_q),
        .share_in(share_in),
        .share_oe_q(share_oe),
        .meas(meas.shr)
    );

    assign trim_up = meas.trim_q;

    // ------------------------------------------------------------------
    // fault sources
    // ------------------------------------------------------------------
    // bit 0 overheat, bits 3:1 fault pins; injection ORs onto the same path
    assign fault_src = {fault_s, meas.temp_q >= otlim_q} | inject_q;
    // a low health line not of our making is a fault of the group; our
    // own release needs two synchroniser cycles to reach health_s
    assign group_down = !health_s && !health_oe_q && !(|oe_hist_q);
    assign fault_now = (|fault_src) || group_down;
    assign latching = |(fault_src & latsel_q);
    assign enable = ctrl_on_q && en_s;
    assign hic_done = hic_cnt_q == HW'(HIC_EDGES - 1);

    // ------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (enable) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    state_d = ST_OFF;
                end else if (fault_now) begin
                    state_d = latching ? ST_LAT : ST_FLT;
                end
            end
            ST_FLT: begin
                if (!enable) begin
                    state_d = ST_OFF;
                end else if (!fault_now) begin
                    state_d = ST_HIC;
                end
            end
            ST_HIC: begin
                if (!enable) begin
                    state_d = ST_OFF;
                end else if (fault_now) begin
                    state_d = ST_FLT;
                end else if (sd_fall && hic_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_LAT: begin
                // trigger removal alone never leaves here
                if (!enable) begin
                    state_d = ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_OFF;
            pwr_en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pwr_en_q <= state_d == ST_RUN;
        end
    end

    // locked switching clock is the falling sync edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hic_cnt_q <= '0;
        end else if (state_q != ST_HIC) begin
            hic_cnt_q <= '0;
        end else if (sd_fall) begin
            hic_cnt_q <= HW'(hic_cnt_q + 1'b1);
        end
    end

    // group members pull the line together, on the shared clock edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            health_oe_q <= 1'b0;
        end else if (sd_fall) begin
            health_oe_q <= state_q == ST_FLT || state_q == ST_LAT;
        end
    end

    // ------------------------------------------------------------------
    // interrupts; a new event wins over its clear
    // ------------------------------------------------------------------
    always_comb begin
        ev = 4'h0;
        ev[`RMFC_EV_FAULT] = state_q == ST_RUN &&
            (state_d == ST_FLT || state_d == ST_LAT);
        ev[`RMFC_EV_RESTART] = state_q == ST_HIC && state_d == ST_RUN;
        ev[`RMFC_EV_CLEAR] = state_q == ST_LAT && state_d == ST_OFF;
        ev[`RMFC_EV_MEAS] = meas.upd_q;
        istat_d = istat_q;
        if (reg_wr && hit(reg_addr, `RMFC_A_ISTAT)) begin
            istat_d = istat_q & ~reg_wdata[3:0];
        end
        istat_d = istat_d | ev;
        imask_d = imask_q;
        if (reg_wr && hit(reg_addr, `RMFC_A_IMASK)) begin
            imask_d = reg_wdata[3:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            istat_q <= 4'h0;
            imask_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q <= |(istat_d & imask_d);
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_on_q <= 1'b0;
            inject_q <= 4'h0;
            latsel_q <= 4'h0;
            otlim_q <= `RMFC_OTLIM_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, `RMFC_A_CTRL)) begin
                ctrl_on_q <= reg_wdata[`RMFC_CTRL_ON];
            end
            if (hit(reg_addr, `RMFC_A_INJECT)) begin
                inject_q <= reg_wdata[3:0];
            end
            if (hit(reg_addr, `RMFC_A_LATSEL)) begin
                latsel_q <= reg_wdata[3:0];
            end
            if (hit(reg_addr, `RMFC_A_OTLIM)) begin
                otlim_q <= reg_wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // read port: data stands one cycle, zero otherwise
    // ------------------------------------------------------------------
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`RMFC_ST_STATE +: 5] = state_q;
        status_w[`RMFC_ST_FAULT +: 4] = fault_src;
        status_w[`RMFC_ST_GRPDN] = group_down;
        status_w[`RMFC_ST_TRIM] = meas.trim_q;
        case (reg_addr)
            `RMFC_A_CTRL: rd_val = {31'h0000_0000, ctrl_on_q};
            `RMFC_A_INJECT: rd_val = {28'h000_0000, inject_q};
            `RMFC_A_LATSEL: rd_val = {28'h000_0000, latsel_q};
            `RMFC_A_OTLIM: rd_val = {24'h00_0000, otlim_q};
            `RMFC_A_STATUS: rd_val = status_w;
            `RMFC_A_VOUT: rd_val = {20'h0_0000, meas.vout_q};
            `RMFC_A_IOUT: rd_val = {24'h00_0000, meas.iout_q};
            `RMFC_A_TEMP: rd_val = {24'h00_0000, meas.temp_q};
            `RMFC_A_DUTY: rd_val = {24'h00_0000, meas.duty_q};
            `RMFC_A_ISTAT: rd_val = {28'h000_0000, istat_q};
            `RMFC_A_IMASK: rd_val = {28'h000_0000, imask_q};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_inject_stops: assert property (
        state_q == ST_RUN && inject_q != 4'h0 |=> !pwr_en_q [*2])
        else $error("injected fault did not stop the regulator");
    a_fault_stops: assert property (
        state_q == ST_RUN && enable && fault_now
        |=> state_q inside {ST_FLT, ST_LAT} && !pwr_en_q)
        else $error("fault did not shut the regulator down");
    a_hic_start: assert property (
        state_q == ST_FLT && enable && !fault_now
        |=> state_q == ST_HIC && hic_cnt_q == '0)
        else $error("hiccup count not started at fault removal");
    a_hic_length: assert property (
        state_q == ST_RUN && $past(state_q) == ST_HIC
        |-> $past(hic_cnt_q) == HW'(HIC_EDGES - 1))
        else $error("restart before hiccup time");
    a_lat_holds: assert property (
        state_q == ST_LAT && enable |=> state_q == ST_LAT)
        else $error("latched fault left without clear");
    a_lat_clear: assert property (
        state_q == ST_LAT && !en_s |=> state_q == ST_OFF ##1
        (state_q == ST_OFF || !enable || state_q == ST_RUN))
        else $error("on pin toggle did not clear latch");
    a_health_edge: assert property (
        $changed(health_oe_q) |-> $past(sd_fall))
        else $error("health line changed off the sync edge");
    a_irq_level: assert property (
        (istat_q & imask_q) != 4'h0 |-> irq_q)
        else $error("interrupt low with unmasked status");

    c_hic_restart: cover property (state_q == ST_HIC ##1 state_q == ST_RUN);
    c_lat_clear: cover property (state_q == ST_LAT ##1 state_q == ST_OFF);
    c_trim: cover property (pwr_en_q && meas.trim_q);
endmodule : rmfc_top
`default_nettype wire

/* verif/rmfc_mgr_model.sv */
/* power manager model: free-running sync clock, group line pull-up.
 * assumes a single regulator on the group health line. */
`timescale 1ns/10ps
`default_nettype none
module rmfc_mgr_model (
    // lines
    output logic sync_data_line,
    input wire logic health_oe,
    output logic health_in
);
    initial sync_data_line = 1'b1;
    // master clock never stops: it is the switching clock as well
    always #160 sync_data_line = ~sync_data_line;
    assign health_in = ~health_oe;
endmodule : rmfc_mgr_model
`default_nettype wire

/* verif/tb.sv */
/* self-checking bench of rmfc_top with converter and share wire models.
 * assumes HIC_EDGES of 20 and a 320 ns sync period. */
`timescale 1ns/10ps
`default_nettype none
`include "rmfc_cfg.svh"
module tb;
    import rmfc_pkg::*;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, en_pin = 0;
    logic adc_done = 0, sync_data_line, health_in, health_oe_q, share_in;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_q, vnext = 0;
    logic [11:0] adc_data = 12'h000;
    logic [2:0] fault_pin = 3'h0;
    logic share_oe, trim_up, adc_start, pwr_en_q, irq_q, peer_low = 0;
    logic [7:0] tnext = 8'h39;
    rmfc_chan_t adc_chan;
    integer failures = 0, check_count = 0, seed = 92, n, dly = 0;
    always #20 ref_clk = ~ref_clk;
    // a paralleled peer that can hold the share line low
    assign share_in = ~(share_oe | peer_low);
    rmfc_top #(.HIC_EDGES(20)) DUT (.ref_clk, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .sync_data_line, .health_in,
        .health_oe_q, .share_in, .share_oe, .trim_up, .adc_done, .adc_data,
        .adc_start, .adc_chan, .fault_pin, .en_pin, .pwr_en_q, .irq_q);
    rmfc_mgr_model mgr (.sync_data_line, .health_oe(health_oe_q),
        .health_in);
    // converter: current fixed at 0x80, temperature from tnext
    always @(posedge ref_clk) begin
        adc_done <= 1'b0;
        if (adc_start) dly <= 3;
        else if (dly > 1) dly <= dly - 1;
        else if (dly == 1) begin
            dly <= 0;
            adc_done <= 1'b1;
            adc_data <= (adc_chan == CH_VOUT) ? vnext[11:0] :
                (adc_chan == CH_IOUT) ? 12'h0800 : {tnext, 4'h0};
        end
    end
    task cyc(input integer k);
        repeat (k) @(posedge ref_clk);
    endtask : cyc
    task chk(input [31:0] g, input [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rdc(input [7:0] a, input [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, e);
    endtask : rdc
    task complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        #1_000_000 failures++;
        complete_run();
    end
    initial begin
        cyc(2);
        rst <= 1'b0;
        rdc(`RMFC_A_OTLIM, 32'h0000_007D);
        rdc(8'h30, 32'h0000_0000);
        rdc(`RMFC_A_STATUS, 32'h0000_0001);
        repeat (4) begin
            vnext = $random(seed);
            cyc(40);
            rdc(`RMFC_A_VOUT, {20'h0_0000, vnext[11:0]});
        end
        // 0x80 less one eighth for 0x20 above reference temperature
        rdc(`RMFC_A_IOUT, 32'h0000_0070);
        rdc(`RMFC_A_TEMP, 32'h0000_0039);
        tnext = `RMFC_TREF;
        cyc(60);
        // no correction at the reference temperature
        rdc(`RMFC_A_IOUT, 32'h0000_0080);
        tnext = 8'h39;
        $display("readings test done");
        wr(`RMFC_A_IMASK, 32'h0000_0001);
        en_pin <= 1'b1;
        wr(`RMFC_A_CTRL, 32'h0000_0001);
        cyc(600);
        n = 0;
        repeat (256) begin
            @(posedge ref_clk);
            n += share_oe;
        end
        chk(n, 32'h0000_0070);
        rdc(`RMFC_A_STATUS, 32'h0000_0002);
        rdc(`RMFC_A_DUTY, 32'h0000_0070);
        peer_low <= 1'b1;
        cyc(600);
        chk({31'h0, trim_up}, 1);
        rdc(`RMFC_A_STATUS, 32'h0000_2002);
        peer_low <= 1'b0;
        cyc(600);
        chk({31'h0, trim_up}, 0);
        $display("share test done");
        wr(`RMFC_A_INJECT, 32'h0000_0001);
        cyc(80);
        chk({31'h0, pwr_en_q}, 0);
        chk({31'h0, irq_q}, 1);
        chk({31'h0, health_oe_q}, 1);
        rdc(`RMFC_A_STATUS, 32'h0000_0104);
        wr(`RMFC_A_ISTAT, 32'h0000_0001);
        wr(`RMFC_A_INJECT, 32'h0000_0000);
        cyc(120);
        chk({31'h0, pwr_en_q}, 0);
        cyc(80);
        chk({31'h0, pwr_en_q}, 1);
        chk({31'h0, irq_q}, 0);
        $display("hiccup test done");
        wr(`RMFC_A_LATSEL, 32'h0000_0001);
        wr(`RMFC_A_INJECT, 32'h0000_0001);
        cyc(5);
        wr(`RMFC_A_INJECT, 32'h0000_0000);
        cyc(300);
        rdc(`RMFC_A_STATUS, 32'h0000_0010);
        en_pin <= 1'b0;
        cyc(5);
        rdc(`RMFC_A_STATUS, 32'h0000_0001);
        en_pin <= 1'b1;
        cyc(5);
        chk({31'h0, pwr_en_q}, 1);
        wr(`RMFC_A_LATSEL, 32'h0000_0002);
        fault_pin <= 3'h1;
        cyc(8);
        rdc(`RMFC_A_STATUS, 32'h0000_0210);
        fault_pin <= 3'h0;
        wr(`RMFC_A_CTRL, 32'h0000_0000);
        wr(`RMFC_A_CTRL, 32'h0000_0001);
        cyc(5);
        chk({31'h0, pwr_en_q}, 1);
        $display("latch test done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
